// ### hdl/fbcm_pkg.sv
// Package for the free buffer congestion monitor: register map, fields, reset values
package fbcm_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 16;
  localparam int EXP_W = 4;
  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] RX_CFG_IDX = 24'h1F0000;
  localparam logic [ADDR_W-1:0] RX_STATE_IDX = 24'h1F0001;
  localparam logic [ADDR_W-1:0] TX_CFG_IDX = 24'h1F0008;
  localparam logic [ADDR_W-1:0] TX_STATE_IDX = 24'h1F0009;
  localparam logic [ADDR_W-1:0] CTRL_IDX = 24'h1F00F0;
  // Field positions
  localparam int EXP_LSB = 8;
  localparam int RSV_CFG_LSB = 12;
  localparam int CONG_BIT = 16;
  localparam int RSV_STATE_BIT = 17;
  localparam int SWRST_BIT = 0;
  // Reset values
  localparam logic [EXP_W-1:0] EXP_RESET = 4'h0;
  localparam logic [EXP_W-1:0] RSV_CFG_RESET = 4'h3;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h00000000;

  typedef struct packed {
    logic alloc;
    logic dealloc;
  } fbcm_bufev_s;

  typedef struct packed {
    logic [EXP_W-1:0] exponent;
    logic [EXP_W-1:0] rsvCfg;
    logic [COUNT_W-1:0] count;
    logic congested;
    logic rsvState;
  } fbcm_dir_s;
endpackage

// ### hdl/fbcm_monitor.sv
// Free buffer congestion monitor for the receive and transmit directions
// Functional notes
// - Enter congestion when free count drops below the exponent threshold.
// - Leave congestion when free count exceeds twice the threshold, or by a state write in software reset.
// - Receive congestion drives the congestion action output; small exponent means late.
// - Sixteen-bit empty buffer count per direction in state low field.
// - Congestion bit starts at zero; transmit congestion bit is read-only.
//
// Added by the designer: the strobed register port.
module fbcm_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [fbcm_pkg::ADDR_W-1:0] regAddr,
  input wire logic [fbcm_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [fbcm_pkg::DATA_W-1:0] regRdData,
  input wire fbcm_pkg::fbcm_bufev_s rxEvent,
  input wire fbcm_pkg::fbcm_bufev_s txEvent,
  output logic rxFreeCongested,
  output logic txFreeCongested,
  output logic softwareResetBit
);
  fbcm_pkg::fbcm_dir_s rxDir, txDir;
  logic swRst_r, swRst_nxt;
  logic [fbcm_pkg::DATA_W-1:0] rdData_r, rdData_nxt;
  logic counting;
  logic rxCfgWr;
  logic rxStateWr;
  logic txCfgWr;
  logic txStateWr;

  // Counting halts in software reset so loaded values are not disturbed
  assign counting = !swRst_r;
  // Write strobes decoded once here and handed to each direction
  assign rxCfgWr = regWr && regAddr == fbcm_pkg::RX_CFG_IDX;
  assign txCfgWr = regWr && regAddr == fbcm_pkg::TX_CFG_IDX;
  // state loads only during software reset
  assign rxStateWr = regWr && regAddr == fbcm_pkg::RX_STATE_IDX && swRst_r;
  assign txStateWr = regWr && regAddr == fbcm_pkg::TX_STATE_IDX && swRst_r;

  always_comb
  begin
    swRst_nxt = swRst_r;
    if (regWr && regAddr == fbcm_pkg::CTRL_IDX)
      swRst_nxt = regWrData[fbcm_pkg::SWRST_BIT];
  end

  function automatic logic [fbcm_pkg::DATA_W-1:0] cfgWord(input fbcm_pkg::fbcm_dir_s d);
    logic [fbcm_pkg::DATA_W-1:0] w;
    w = '0;
    w[fbcm_pkg::EXP_LSB +: fbcm_pkg::EXP_W] = d.exponent;
    w[fbcm_pkg::RSV_CFG_LSB +: fbcm_pkg::EXP_W] = d.rsvCfg;
    return w;
  endfunction

  function automatic logic [fbcm_pkg::DATA_W-1:0] stateWord(input fbcm_pkg::fbcm_dir_s d);
    logic [fbcm_pkg::DATA_W-1:0] w;
    w = '0;
    w[fbcm_pkg::COUNT_W-1:0] = d.count;
    w[fbcm_pkg::CONG_BIT] = d.congested;
    w[fbcm_pkg::RSV_STATE_BIT] = d.rsvState;
    return w;
  endfunction

  always_comb
  begin
    rdData_nxt = rdData_r;
    if (regRd)
    begin
      unique case (regAddr)
        fbcm_pkg::CTRL_IDX:
        begin
          rdData_nxt = '0;
          rdData_nxt[fbcm_pkg::SWRST_BIT] = swRst_r;
        end
        fbcm_pkg::RX_CFG_IDX:
          rdData_nxt = cfgWord(rxDir);
        fbcm_pkg::TX_CFG_IDX:
          rdData_nxt = cfgWord(txDir);
        fbcm_pkg::RX_STATE_IDX:
          rdData_nxt = stateWord(rxDir);
        fbcm_pkg::TX_STATE_IDX:
          rdData_nxt = stateWord(txDir);
        default:
          rdData_nxt = fbcm_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      swRst_r <= 1'b1;
      rdData_r <= '0;
      softwareResetBit <= 1'b1;
    end
    else if (clkEn)
    begin
      swRst_r <= swRst_nxt;
      rdData_r <= rdData_nxt;
      softwareResetBit <= swRst_nxt;
    end
  end

  // Read data holds between reads; only the cycle after a read is promised
  assign regRdData = rdData_r;

  // receive congestion flag drives the action output
  fbcm_dir_track #(
    .CONG_WRITABLE(1'b1)
  ) u_rx (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .counting(counting),
    .cfgWr(rxCfgWr),
    .stateWr(rxStateWr),
    .wrData(regWrData),
    .bufEv(rxEvent),
    .dir(rxDir),
    .congested(rxFreeCongested)
  );

  // transmit congestion bit is read-only to software
  fbcm_dir_track #(
    .CONG_WRITABLE(1'b0)
  ) u_tx (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .counting(counting),
    .cfgWr(txCfgWr),
    .stateWr(txStateWr),
    .wrData(regWrData),
    .bufEv(txEvent),
    .dir(txDir),
    .congested(txFreeCongested)
  );
endmodule

// One direction: empty-buffer count and congestion state with hysteresis
module fbcm_dir_track #(
  parameter bit CONG_WRITABLE = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic counting,
  input wire logic cfgWr,
  input wire logic stateWr,
  input wire logic [fbcm_pkg::DATA_W-1:0] wrData,
  input wire fbcm_pkg::fbcm_bufev_s bufEv,
  output fbcm_pkg::fbcm_dir_s dir,
  output logic congested
);
  fbcm_pkg::fbcm_dir_s dir_r, dir_nxt;
  // Extra bits so the largest exponent cannot wrap the threshold
  logic [fbcm_pkg::COUNT_W:0] thr;
  logic [fbcm_pkg::COUNT_W+1:0] thr2;

  always_comb
  begin
    dir_nxt = dir_r;
    // threshold is a power of two
    thr = {{fbcm_pkg::COUNT_W{1'b0}}, 1'b1} << dir_r.exponent;
    thr2 = {1'b0, thr} << 1;
    if (counting)
    begin
      // count follows alloc and release; both at once cancel
      if (bufEv.alloc && !bufEv.dealloc)
        dir_nxt.count = dir_r.count - 16'h0001;
      else if (bufEv.dealloc && !bufEv.alloc)
        dir_nxt.count = dir_r.count + 16'h0001;
      if (!dir_r.congested && {1'b0, dir_nxt.count} < thr)
        dir_nxt.congested = 1'b1;
      else if (dir_r.congested && {2'b00, dir_nxt.count} > thr2)
        dir_nxt.congested = 1'b0;
    end
    if (cfgWr)
    begin
      dir_nxt.exponent = wrData[fbcm_pkg::EXP_LSB +: fbcm_pkg::EXP_W];
      dir_nxt.rsvCfg = wrData[fbcm_pkg::RSV_CFG_LSB +: fbcm_pkg::EXP_W];
    end
    // Loads only arrive while counting is halted, so they never race a step
    if (stateWr)
    begin
      dir_nxt.count = wrData[fbcm_pkg::COUNT_W-1:0];
      // read-only copy ignores the written bit and clears instead
      dir_nxt.congested = CONG_WRITABLE ? wrData[fbcm_pkg::CONG_BIT] : 1'b0;
      dir_nxt.rsvState = wrData[fbcm_pkg::RSV_STATE_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dir_r <= '{fbcm_pkg::EXP_RESET, fbcm_pkg::RSV_CFG_RESET, fbcm_pkg::COUNT_RESET,
        1'b0, 1'b0};
      congested <= 1'b0;
    end
    else if (clkEn)
    begin
      dir_r <= dir_nxt;
      congested <= dir_nxt.congested;
    end
  end

  assign dir = dir_r;
endmodule

// ### verif/fbcm_monitor_asserts.sv
// Port checker for the free buffer congestion monitor
module fbcm_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire fbcm_pkg::fbcm_bufev_s rxEvent,
  input wire fbcm_pkg::fbcm_bufev_s txEvent,
  input wire logic rxFreeCongested,
  input wire logic txFreeCongested,
  input wire logic softwareResetBit
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_rxUp;
    $rose(rxFreeCongested) |-> $past(rxEvent.alloc || regWr);
  endproperty
  a_rxUp: assert property (p_rxUp) else $error("rx entry");
  property p_rxDn;
    $fell(rxFreeCongested) |-> $past(rxEvent.dealloc || regWr);
  endproperty
  a_rxDn: assert property (p_rxDn) else $error("rx exit");
  property p_txUp;
    $rose(txFreeCongested) |-> $past(txEvent.alloc || regWr);
  endproperty
  a_txUp: assert property (p_txUp) else $error("tx entry");
  property p_txDn;
    $fell(txFreeCongested) |-> $past(txEvent.dealloc || regWr);
  endproperty
  a_txDn: assert property (p_txDn) else $error("tx exit");
  property p_hold;
    softwareResetBit && !regWr |=> $stable(txFreeCongested) && $stable(rxFreeCongested);
  endproperty
  a_hold: assert property (p_hold) else $error("count in reset");
  property p_rdHold;
    !regRd |=> $stable(regRdData);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data");
  property p_txBit;
    softwareResetBit |=> !$rose(txFreeCongested);
  endproperty
  a_txBit: assert property (p_txBit) else $error("tx bit");
endmodule
bind fbcm_monitor fbcm_chk u_chk (.clk(clk), .rst(rst), .clkEn(clkEn), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .rxEvent(rxEvent), .txEvent(txEvent),
  .rxFreeCongested(rxFreeCongested), .txFreeCongested(txFreeCongested),
  .softwareResetBit(softwareResetBit));

// ### verif/fbcm_monitor_test.sv
// Self-checking bench for the free buffer congestion monitor
module fbcm_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, regWr = 0, regRd = 0, rxC, txC, en = 1, swB;
  logic [23:0] regAddr = '0;
  logic [31:0] regWrData = '0, regRdData;
  fbcm_pkg::fbcm_bufev_s rxEv = '0, txEv = '0;
  int n_fail = 0, check_count = 0, cyc = 0;
  fbcm_monitor dut (.clk(clk), .rst(rst), .clkEn(en), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .rxEvent(rxEv), .txEvent(txEv), .rxFreeCongested(rxC),
    .txFreeCongested(txC), .softwareResetBit(swB));
  always #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h not %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [31:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  // Events held n cycles, then flags compared
  task automatic ev(input logic [1:0] r, input logic [1:0] t, input int n, input logic [1:0] e);
    @(posedge clk);
    rxEv <= r;
    txEv <= t;
    repeat (n) @(posedge clk);
    rxEv <= '0;
    txEv <= '0;
    #1 chk(32'({rxC, txC}), 32'(e));
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 400)
    begin
      n_fail++;
      stop_test;
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(24'h1F0000, 32'h00003000);
    rd(24'h1F0009, 32'h00000000);
    rd(24'h1F00F0, 32'h00000001);
    chk(32'(swB), 32'h00000001);
    wr(24'h1F0000, 32'h00003200);
    wr(24'h1F0001, 32'h00000005);
    rd(24'h1F0001, 32'h00000005);
    wr(24'h1F0008, 32'h00003100);
    rd(24'h1F0008, 32'h00003100);
    wr(24'h1F0009, 32'h00010003);
    rd(24'h1F0009, 32'h00000003);
    wr(24'h1F00F0, 32'h00000000);
    ev(2'b10, 2'b10, 1, 2'b00);
    chk(32'(swB), 32'h00000000);
    ev(2'b10, 2'b10, 1, 2'b11);
    rd(24'h1F0009, 32'h00010001);
    ev(2'b11, 2'b11, 3, 2'b11);
    ev(2'b01, 2'b01, 5, 2'b10);
    ev(2'b01, 2'b00, 1, 2'b00);
    rd(24'h1F0001, 32'h00000009);
    rd(24'h1F0009, 32'h00000006);
    // Count writes refused once running
    wr(24'h1F0001, 32'h00000055);
    rd(24'h1F0001, 32'h00000009);
    rd(24'h1F0002, 32'h00000000);
    // Clock enable low: releases must not move the counts
    @(posedge clk);
    en <= 1'b0;
    ev(2'b01, 2'b01, 2, 2'b00);
    @(posedge clk);
    en <= 1'b1;
    rd(24'h1F0001, 32'h00000009);
    rd(24'h1F0009, 32'h00000006);
    stop_test;
  end
endmodule
